// ===== inc/pbv_pkg.sv
// shared constants for the buck voltage serial slave
package pbv_pkg;
  localparam logic [6:0] SLAVE_ADDR       = 7'h68;  // 1101000
  localparam logic [7:0] BUCK_ONE_OFFSET  = 8'h00;
  localparam logic [7:0] BUCK_TWO_OFFSET  = 8'h01;
  localparam logic [6:0] VCODE_RESET      = 7'h10;
  localparam logic [6:0] VCODE_MAX        = 7'h6f;  // 3.600 V
  localparam int         VCODE_BASE_MV    = 825;
  localparam int         VCODE_STEP_MV    = 25;
  localparam int         VCODE_FIELD_MSB  = 6;
  localparam int         RESERVED_BIT     = 7;
  localparam int         DIR_BIT          = 0;
  localparam int         MAX_RATE_KBPS    = 400;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_RX   = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } pbv_state_t;
endpackage

// ===== logic/pbv_sync.sv
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module pbv_sync
(
  input  wire logic clock_in,    // system clock
  input  wire logic reset_n_in,  // async reset, active low
  input  wire logic async_in,    // pin level
  output logic      level_out,   // synchronised level
  output logic      rise_out,    // one-cycle rising edge
  output logic      fall_out     // one-cycle falling edge
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // lines idle high through their pull-ups
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out  = sync_r & ~prev_r;
  assign fall_out  = ~sync_r & prev_r;
endmodule // pbv_sync

// ===== logic/pbv_slave.sv
// two-wire serial slave with the two buck voltage-code registers
// How it works
// - slave only; acknowledges address 1101000, ignores every other address
// - bit after the address: zero means master writes, one means reads
// - supports write, pointer-then-restart read, and read at current pointer
// - both registers take their reset value at start-up before any access
// - first converter code at pointer 0x00, second at 0x01
// - eight bits: top bit reserved reads zero, low seven reset to 0x10
// - code 00 is 0.825 V, plus 25 mV per step, 6F is 3.600 V
// - open-drain clock and data lines with pull-ups, at most 400 kb/s
`timescale 1ns/1ps
module pbv_slave
  import pbv_pkg::*;
(
  input  wire logic       clock_in,                // 200 MHz system clock
  input  wire logic       reset_n_in,              // async reset, active low
  input  wire logic       serial_clock_in,         // bus clock pin level
  input  wire logic       serial_data_pin_in,      // data pin level
  output logic            serial_data_pin_out,     // data drive value
  output logic            serial_data_pin_oe_n_out,// low while driving
  output logic [6:0]      first_step_down_converter_out,  // code to buck 1
  output logic [6:0]      second_step_down_converter_out  // code to buck 2
);
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;

  // both pins pass two flops before any logic sees them
  pbv_sync u_scl_sync
  (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (serial_clock_in),
    .level_out  (scl),
    .rise_out   (scl_rise),
    .fall_out   (scl_fall)
  );

  pbv_sync u_sda_sync
  (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (serial_data_pin_in),
    .level_out  (sda),
    .rise_out   (sda_rise),
    .fall_out   (sda_fall)
  );

  logic start_cond;
  logic stop_cond;
  assign start_cond = scl & sda_fall;
  assign stop_cond  = scl & sda_rise;

  pbv_state_t state_r;
  pbv_state_t state_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic       rd_mode_r;
  logic       rd_mode_nxt;
  logic       ptr_phase_r;     // next written byte is the pointer
  logic       ptr_phase_nxt;
  logic [7:0] pointer_r;
  logic [7:0] pointer_nxt;
  logic [6:0] code_r     [2];
  logic [6:0] code_nxt   [2];
  logic       drive_low_r;
  logic       drive_low_nxt;
  logic       mack_ok_r;
  logic       mack_ok_nxt;

  // reserved bit reads as zero
  function automatic logic [7:0] read_reg(input logic [7:0] ptr,
                                          input logic [6:0] c0,
                                          input logic [6:0] c1);
    logic [7:0] v;
    v = 8'h00;
    if (ptr == BUCK_ONE_OFFSET)
      v = {1'b0, c0};
    else if (ptr == BUCK_TWO_OFFSET)
      v = {1'b0, c1};
    return v;
  endfunction

  always_comb
  begin
    state_nxt     = state_r;
    shift_nxt     = shift_r;
    bit_cnt_nxt   = bit_cnt_r;
    rd_mode_nxt   = rd_mode_r;
    ptr_phase_nxt = ptr_phase_r;
    pointer_nxt   = pointer_r;
    code_nxt      = code_r;
    drive_low_nxt = drive_low_r;
    mack_ok_nxt   = mack_ok_r;
    if (start_cond)
    begin
      // a repeated start keeps the pointer for the restarted read
      state_nxt     = ST_ADDR;
      bit_cnt_nxt   = 4'h0;
      drive_low_nxt = 1'b0;
    end
    else if (stop_cond)
    begin
      state_nxt     = ST_IDLE;
      drive_low_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          drive_low_nxt = 1'b0;
        end
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shift_nxt   = {shift_r[6:0], sda};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            bit_cnt_nxt = 4'h0;
            if (state_r == ST_ADDR)
            begin
              // foreign addresses are ignored, no ack
              if (shift_r[7:1] == SLAVE_ADDR)
              begin
                rd_mode_nxt   = shift_r[DIR_BIT];
                ptr_phase_nxt = ~shift_r[DIR_BIT];
                drive_low_nxt = 1'b1;
                state_nxt     = ST_ACK;
              end
              else
                state_nxt = ST_IDLE;
            end
            else
            begin
              drive_low_nxt = 1'b1;
              state_nxt     = ST_ACK;
              if (ptr_phase_r)
              begin
                pointer_nxt   = shift_r;
                ptr_phase_nxt = 1'b0;
              end
              else
              begin
                // codes above the top step are stored but undefined
                if (pointer_r == BUCK_ONE_OFFSET)
                  code_nxt[0] = shift_r[VCODE_FIELD_MSB:0];
                else if (pointer_r == BUCK_TWO_OFFSET)
                  code_nxt[1] = shift_r[VCODE_FIELD_MSB:0];
                pointer_nxt = pointer_r + 8'h01;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (rd_mode_r)
            begin
              // read at current pointer, pointer-first or not
              shift_nxt     = read_reg(pointer_r, code_r[0], code_r[1]);
              drive_low_nxt = ~shift_nxt[7];
              bit_cnt_nxt   = 4'h1;
              state_nxt     = ST_TX;
            end
            else
            begin
              drive_low_nxt = 1'b0;
              state_nxt     = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              drive_low_nxt = 1'b0;
              bit_cnt_nxt   = 4'h0;
              pointer_nxt   = pointer_r + 8'h01;
              state_nxt     = ST_MACK;
            end
            else
            begin
              shift_nxt     = {shift_r[6:0], 1'b0};
              drive_low_nxt = ~shift_r[6];
              bit_cnt_nxt   = bit_cnt_r + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            mack_ok_nxt = ~sda;
          else if (scl_fall)
          begin
            if (mack_ok_r)
            begin
              shift_nxt     = read_reg(pointer_r, code_r[0], code_r[1]);
              drive_low_nxt = ~shift_nxt[7];
              bit_cnt_nxt   = 4'h1;
              state_nxt     = ST_TX;
            end
            else
              state_nxt = ST_IDLE;
          end
        end
        default:
        begin
          state_nxt     = ST_IDLE;
          drive_low_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r     <= ST_IDLE;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 4'h0;
      rd_mode_r   <= 1'b0;
      ptr_phase_r <= 1'b0;
      pointer_r   <= BUCK_ONE_OFFSET;
      code_r[0]   <= VCODE_RESET;
      code_r[1]   <= VCODE_RESET;
      drive_low_r <= 1'b0;
      mack_ok_r   <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      shift_r     <= shift_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      rd_mode_r   <= rd_mode_nxt;
      ptr_phase_r <= ptr_phase_nxt;
      pointer_r   <= pointer_nxt;
      code_r      <= code_nxt;
      drive_low_r <= drive_low_nxt;
      mack_ok_r   <= mack_ok_nxt;
    end
  end

  // open drain: only ever pull low
  assign serial_data_pin_out      = 1'b0;
  assign serial_data_pin_oe_n_out = ~drive_low_r;
  assign first_step_down_converter_out  = code_r[0];
  assign second_step_down_converter_out = code_r[1];
endmodule // pbv_slave

// ===== bench/pbv_slave_asserts.sv
// concurrent checks on the serial slave ports
`timescale 1ns/1ps
module pbv_slave_asserts
  import pbv_pkg::*;
(
  input wire logic       clock_in,                       // system clock
  input wire logic       reset_n_in,                     // async reset
  input wire logic       serial_clock_in,                // bus clock
  input wire logic       serial_data_pin_in,             // data line
  input wire logic       serial_data_pin_out,            // drive value
  input wire logic       serial_data_pin_oe_n_out,       // drive enable
  input wire logic [6:0] first_step_down_converter_out,  // buck 1 code
  input wire logic [6:0] second_step_down_converter_out  // buck 2 code
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  AST_DRIVE_LOW:
  assert property (serial_data_pin_out == 1'b0)
    else $error("open-drain drive value not low");
  AST_RESET_CODE:
  assert property ($rose(reset_n_in) |-> first_step_down_converter_out
    == VCODE_RESET && second_step_down_converter_out == VCODE_RESET)
    else $error("code not at reset value after start-up");
  AST_CHG_CLK_LOW:
  assert property ($changed(serial_data_pin_oe_n_out) |-> !serial_clock_in)
    else $error("data drive moved while clock high");
  AST_CHG_AFTER_FALL:
  assert property ($changed(serial_data_pin_oe_n_out)
    |-> $past(serial_clock_in, 5))
    else $error("data drive moved without a clock fall");
  AST_HOLD_HIGH:
  assert property ($rose(serial_clock_in)
    |-> $stable(serial_data_pin_oe_n_out) [*6])
    else $error("data drive not held over clock high");
  AST_DRIVE_HOLD:
  assert property ($fell(serial_data_pin_oe_n_out)
    |-> !serial_data_pin_oe_n_out [*4])
    else $error("drive pulse too short");
  AST_ONE_REG:
  assert property (!$stable(first_step_down_converter_out)
    |-> $stable(second_step_down_converter_out))
    else $error("both codes changed together");
  AST_CODE_AT_ACK:
  assert property (!$stable(first_step_down_converter_out)
    || !$stable(second_step_down_converter_out)
    |-> !serial_data_pin_oe_n_out || !$past(serial_data_pin_oe_n_out))
    else $error("code changed outside acknowledge");
  COV_ACK: cover property ($fell(serial_data_pin_oe_n_out));
  COV_ONE: cover property ($changed(first_step_down_converter_out));
  COV_TWO: cover property ($changed(second_step_down_converter_out));
endmodule // pbv_slave_asserts

bind pbv_slave pbv_slave_asserts u_chk
(
  .clock_in                       (clock_in),
  .reset_n_in                     (reset_n_in),
  .serial_clock_in                (serial_clock_in),
  .serial_data_pin_in             (serial_data_pin_in),
  .serial_data_pin_out            (serial_data_pin_out),
  .serial_data_pin_oe_n_out       (serial_data_pin_oe_n_out),
  .first_step_down_converter_out  (first_step_down_converter_out),
  .second_step_down_converter_out (second_step_down_converter_out)
);

// ===== bench/pbv_host_model.sv
// bus master model pulling the open-drain clock and data lines
`timescale 1ns/1ps
module pbv_host_model
(
  input  wire logic clock_in,      // pacing clock
  input  wire logic sda_in,        // resolved data line
  output logic      scl_oe_n_out,  // low pulls clock line
  output logic      sda_oe_n_out   // low pulls data line
);
  initial {scl_oe_n_out, sda_oe_n_out} = 2'b11;
  // quarter bit; four make one 80 ns bit, well above the bus ceiling
  // so that runs stay short; the slave only needs a few clocks per phase
  task automatic tick();
    repeat (4) @(negedge clock_in);
  endtask
  // data moves only while the clock is low; released means pulled up
  task automatic bit_io(input logic b, output logic r);
    sda_oe_n_out = b;
    tick();
    scl_oe_n_out = 1'b1;
    tick();
    r = sda_in;
    tick();
    scl_oe_n_out = 1'b0;
    tick();
  endtask
  // serves as start and as repeated start
  task automatic start();
    sda_oe_n_out = 1'b1;
    tick();
    scl_oe_n_out = 1'b1;
    tick();
    sda_oe_n_out = 1'b0;
    tick();
    scl_oe_n_out = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_oe_n_out = 1'b0;
    tick();
    scl_oe_n_out = 1'b1;
    tick();
    sda_oe_n_out = 1'b1;
    tick();
  endtask
  // byte out msb first, ninth bit a; direction is bit 0 of address
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule // pbv_host_model

// ===== bench/tb_pbv_slave.sv
// self-checking bench for the buck voltage serial slave
`timescale 1ns/1ps
module tb_pbv_slave
  import pbv_pkg::*;
;
  localparam logic [7:0] WR = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RD = {SLAVE_ADDR, 1'b1};
  logic       clk;
  logic       rst_n;
  logic       scl_oe_n;
  logic       sda_oe_n;
  logic       dut_oe_n;
  logic       dut_do;
  logic [6:0] code1;
  logic [6:0] code2;
  logic [7:0] q;
  logic       k;
  int         err_count;
  int         check_count;
  wire        sda = sda_oe_n & (dut_oe_n | dut_do);

  pbv_slave dut (.clock_in(clk), .reset_n_in(rst_n),
    .serial_clock_in(scl_oe_n), .serial_data_pin_in(sda),
    .serial_data_pin_out(dut_do), .serial_data_pin_oe_n_out(dut_oe_n),
    .first_step_down_converter_out(code1),
    .second_step_down_converter_out(code2));
  pbv_host_model mst (.clock_in(clk), .sda_in(sda),
    .scl_oe_n_out(scl_oe_n), .sda_oe_n_out(sda_oe_n));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] d);
    mst.xfer(d, 1'b1, q, k);
    check({7'h00, k}, 8'h00);
  endtask
  task automatic get(input logic nak, input logic [7:0] exp);
    mst.xfer(8'hff, nak, q, k);
    check(q, exp);
  endtask
  // lines stay released while reset is held
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #400000;
    err_count++;
    $display("mismatch t=%0t watchdog expired", $time);
    summarize();
  end
  initial
  begin
    err_count = 0;
    check_count = 0;
    do_reset();
    check({1'b0, code1}, 8'h10);
    check({1'b0, code2}, 8'h10);
    $display("test reset done");
    mst.start();
    put(WR);
    put(BUCK_TWO_OFFSET);
    put(8'h20);
    mst.stop();
    check({1'b0, code2}, 8'h20);
    check({1'b0, code1}, 8'h10);
    $display("test single write done");
    // burst from pointer 0 with the lowest and highest defined codes
    mst.start();
    put(WR);
    put(BUCK_ONE_OFFSET);
    put(8'h00);
    put({1'b0, VCODE_MAX});
    mst.stop();
    check({1'b0, code1}, 8'h00);
    check({1'b0, code2}, 8'h6f);
    $display("test burst done");
    mst.start();
    put(WR);
    put(BUCK_ONE_OFFSET);
    mst.start();
    put(RD);
    get(1'b0, 8'h00);
    get(1'b1, 8'h6f);
    mst.stop();
    $display("test pointer read done");
    mst.start();
    put(WR);
    put(BUCK_TWO_OFFSET);
    mst.stop();
    mst.start();
    put(RD);
    get(1'b1, 8'h6f);
    mst.stop();
    $display("test current read done");
    // a wrongly taken address would land this pointer and data
    mst.start();
    mst.xfer(8'hd2, 1'b1, q, k);
    check({7'h00, k}, 8'h01);
    mst.xfer(BUCK_TWO_OFFSET, 1'b1, q, k);
    check({7'h00, k}, 8'h01);
    mst.xfer(8'h00, 1'b1, q, k);
    mst.stop();
    check({1'b0, code2}, 8'h6f);
    $display("test foreign address done");
    // the data byte moves the pointer on, so point back before reading
    mst.start();
    put(WR);
    put(BUCK_ONE_OFFSET);
    put(8'ha5);
    mst.start();
    put(WR);
    put(BUCK_ONE_OFFSET);
    mst.start();
    put(RD);
    get(1'b1, 8'h25);
    mst.stop();
    check({1'b0, code1}, 8'h25);
    $display("test reserved bit done");
    // writes beyond the two registers are acked but land nowhere
    mst.start();
    put(WR);
    put(8'h05);
    put(8'h33);
    mst.stop();
    mst.start();
    put(RD);
    get(1'b1, 8'h00);
    mst.stop();
    check({1'b0, code1}, 8'h25);
    check({1'b0, code2}, 8'h6f);
    $display("test unused pointer done");
    do_reset();
    check({1'b0, code1}, 8'h10);
    check({1'b0, code2}, 8'h10);
    mst.start();
    put(RD);
    get(1'b1, 8'h10);
    mst.stop();
    $display("test second reset done");
    summarize();
  end
endmodule // tb_pbv_slave
